// [logic/osc_regs.svh]
// Function
// [RULE_01] After reset the main oscillator is off and the system runs from the slow clock.
// [RULE_02] Clearing the oscillator enable bit clears the stable flag.
// [RULE_03] An enable write clears the stable flag and loads a down-counter ticking at slow/8.
// [RULE_04] The startup count field is 8 bits wide, about 62 ms at most.
// [RULE_05] The stable flag sets when the startup down-counter reaches zero.
// [RULE_06] The interrupt rises when the stable event is set and its mask bit is on.
// [RULE_07] Software programs a startup count that covers the crystal startup time.
// [RULE_08] The frequency counter starts on main clock after the next slow rising edge.
// [RULE_09] At the 16th slow falling edge the counter stops and the ready flag sets.
// [RULE_10] The counter reads as main clock cycles over 16 slow clock periods.
// [RULE_11] For an external clock software sets bypass to 1 and keeps enable at 0.
// [RULE_12] The slow clock comes from the crystal or the RC source by a select signal.
// [RULE_13] The slow clock is never stopped.
// [RULE_14] Each rise of the stable flag clears ready and restarts a measurement.
// [RULE_15] The stable flag stays clear while counting; a new enable write reloads the count.
`ifndef OSC_REGS_SVH
`define OSC_REGS_SVH
`define CTRL_OFFSET     8'h00
`define FREQ_OFFSET     8'h04
`define STATUS_OFFSET   8'h08
`define EVENT_OFFSET    8'h0C
`define MASK_OFFSET     8'h10
`define ENABLE_BIT      0
`define BYPASS_BIT      1
`define COUNT_LSB       8
`define COUNT_MSB       15
`define READY_BIT       16
`define STABLE_BIT      0
`define EVT_STABLE_BIT  0
`define EVT_READY_BIT   1
`define EVT_W           2
`define PRESCALE_LAST   3'h7
`define MEASURE_LAST    5'h0F
`define CTRL_RESET      32'h0000_0000
`define MASK_RESET      2'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// [logic/osc_pkg.sv]
package osc_pkg;
    typedef enum logic [1:0] {
        MEAS_IDLE  = 2'h0,
        MEAS_ARM   = 2'h1,
        MEAS_COUNT = 2'h3,
        MEAS_DONE  = 2'h2
    } meas_state_t;
    typedef logic [7:0]  startup_count_t;
    typedef logic [15:0] freq_count_t;
    function automatic logic [31:0] merge_bytes(logic [31:0] old_w, logic [31:0] new_w,
                                                logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = new_w[i*8 +: 8];
        end
        return res;
    endfunction : merge_bytes
endpackage : osc_pkg

// [logic/startup_timer.sv]
`timescale 1ns/100ps
`include "osc_regs.svh"
module startup_timer
    import osc_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           rstn,
    input  wire logic           load,
    input  wire logic           stop,
    input  wire startup_count_t load_count,
    input  wire logic           slow_rise,
    output logic                stable
);
    logic [2:0]     pre_reg,     pre_next;
    startup_count_t cnt_reg,     cnt_next;
    logic           run_reg,     run_next;
    logic           stable_reg,  stable_next;
    logic           tick;

    assign tick   = run_reg & slow_rise & (pre_reg == `PRESCALE_LAST);
    assign stable = stable_reg;

    always_comb
    begin
        pre_next    = pre_reg;
        cnt_next    = cnt_reg;
        run_next    = run_reg;
        stable_next = stable_reg;
        if (stop)
        begin
            run_next    = 1'b0; // [RULE_02]
            stable_next = 1'b0;
        end
        else if (load)
        begin
            cnt_next    = load_count; // [RULE_03] [RULE_15]
            pre_next    = 3'h0;
            run_next    = 1'b1;
            stable_next = 1'b0;
        end
        else if (run_reg && slow_rise)
        begin
            pre_next = pre_reg + 3'h1; // [RULE_03]
            if (tick)
            begin
                if (cnt_reg <= 8'h01)
                begin
                    cnt_next    = 8'h00;
                    run_next    = 1'b0;
                    stable_next = 1'b1; // [RULE_05]
                end
                else
                    cnt_next = cnt_reg - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            pre_reg    <= 3'h0;
            cnt_reg    <= 8'h00;
            run_reg    <= 1'b0;
            stable_reg <= 1'b0;
        end
        else
        begin
            pre_reg    <= pre_next;
            cnt_reg    <= cnt_next;
            run_reg    <= run_next;
            stable_reg <= stable_next;
        end
    end

    a_run_not_stable: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_15]
        run_reg |-> !stable_reg)
        else $error("stable set while startup counter runs");
    a_zero_sets_stable: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_05]
        (tick && cnt_reg <= 8'h01 && !load && !stop) |=> stable_reg && !run_reg)
        else $error("stable not set when startup count reached zero");
endmodule : startup_timer

// [logic/freq_meter.sv]
`timescale 1ns/100ps
`include "osc_regs.svh"
module freq_meter
    import osc_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rstn,
    input  wire logic  stable,
    input  wire logic  slow_rise,
    input  wire logic  slow_fall,
    input  wire logic  main_rise,
    output freq_count_t freq_count,
    output logic        ready
);
    meas_state_t state_reg,  state_next;
    freq_count_t cnt_reg,    cnt_next;
    logic [4:0]  falls_reg,  falls_next;
    logic        ready_reg,  ready_next;
    logic        prev_reg;
    logic        start;

    assign start      = stable & ~prev_reg;
    assign freq_count = cnt_reg;
    assign ready      = ready_reg;

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        falls_next = falls_reg;
        ready_next = ready_reg;
        unique case (state_reg)
            MEAS_IDLE: ;
            MEAS_ARM:
                if (slow_rise)
                    state_next = MEAS_COUNT; // [RULE_08]
            MEAS_COUNT:
            begin
                if (main_rise)
                    cnt_next = cnt_reg + 16'h0001; // [RULE_10]
                if (slow_fall)
                begin
                    falls_next = falls_reg + 5'h01;
                    if (falls_reg == `MEASURE_LAST)
                    begin
                        state_next = MEAS_DONE; // [RULE_09]
                        ready_next = 1'b1;
                    end
                end
            end
            MEAS_DONE: ;
        endcase
        if (start)
        begin
            state_next = MEAS_ARM; // [RULE_14]
            cnt_next   = 16'h0000;
            falls_next = 5'h00;
            ready_next = 1'b0;
        end
        else if (!stable)
            state_next = MEAS_IDLE;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_reg <= MEAS_IDLE;
            cnt_reg   <= 16'h0000;
            falls_reg <= 5'h00;
            ready_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            falls_reg <= falls_next;
            ready_reg <= ready_next;
            prev_reg  <= stable;
        end
    end

    sequence s_armed_edge;
        state_reg == MEAS_ARM && slow_rise && stable && !start;
    endsequence
    a_count_begins: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_08]
        s_armed_edge |=> state_reg == MEAS_COUNT)
        else $error("measurement did not start on slow rising edge");
    a_done_frozen: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_09]
        (state_reg == MEAS_DONE && stable && !start) |=> $stable(cnt_reg) && ready_reg)
        else $error("frequency counter moved after measurement end");
    a_restart_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_14]
        start |=> !ready_reg && cnt_reg == 16'h0000 && state_reg == MEAS_ARM)
        else $error("measurement not restarted on stable rise");
endmodule : freq_meter

// [logic/main_osc_control.sv]
`timescale 1ns/100ps
`include "osc_regs.svh"
module main_osc_control
    import osc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        slow_xtal,
    input  wire logic        slow_rc,
    input  wire logic        slow_source_select,
    input  wire logic        main_clock,
    output logic             slow_clock,
    output logic             main_osc_enable,
    output logic             osc_bypass_a,
    output logic             main_osc_stable,
    output logic             sys_on_main,
    output logic             irq
);
    // Bus slave state
    logic        aw_full_reg,  aw_full_next;
    logic [7:0]  awaddr_reg,   awaddr_next;
    logic        w_full_reg,   w_full_next;
    logic [31:0] wdata_reg,    wdata_next;
    logic [3:0]  wstrb_reg,    wstrb_next;
    logic        awready_reg,  awready_next;
    logic        wready_reg,   wready_next;
    logic        bvalid_reg,   bvalid_next;
    logic [1:0]  bresp_reg,    bresp_next;
    logic        arready_reg,  arready_next;
    logic        rvalid_reg,   rvalid_next;
    logic [1:0]  rresp_reg,    rresp_next;
    logic [31:0] rdata_reg,    rdata_next;
    // Register file state
    logic [31:0]      ctrl_reg,   ctrl_next;
    logic [`EVT_W-1:0] evt_reg,   evt_next;
    logic [`EVT_W-1:0] mask_reg,  mask_next;
    logic             irq_reg,    irq_next;
    logic             on_main_reg, on_main_next;
    // Pin sampling state
    logic slow_reg, slow_prev_reg, main_reg, main_prev_reg;
    logic stable_prev_reg, ready_prev_reg;

    logic        do_write;
    logic        load_pulse;
    logic        stop_pulse;
    logic        slow_rise;
    logic        slow_fall;
    logic        main_rise;
    logic        stable;
    logic        ready;
    freq_count_t freq_count;
    logic [31:0] ctrl_merged;
    logic [`EVT_W-1:0] evt_set;

    function automatic logic mapped(logic [7:0] a);
        return a == `CTRL_OFFSET || a == `FREQ_OFFSET || a == `STATUS_OFFSET ||
               a == `EVENT_OFFSET || a == `MASK_OFFSET;
    endfunction : mapped

    assign do_write    = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign ctrl_merged = merge_bytes(ctrl_reg, wdata_reg, wstrb_reg);
    assign load_pulse  = do_write && awaddr_reg == `CTRL_OFFSET &&
                         ctrl_merged[`ENABLE_BIT]; // [RULE_03] [RULE_15]
    assign stop_pulse  = do_write && awaddr_reg == `CTRL_OFFSET &&
                         !ctrl_merged[`ENABLE_BIT]; // [RULE_02]
    assign slow_rise   = slow_reg & ~slow_prev_reg;
    assign slow_fall   = ~slow_reg & slow_prev_reg;
    assign main_rise   = main_reg & ~main_prev_reg;
    assign evt_set     = {ready & ~ready_prev_reg, stable & ~stable_prev_reg};

    startup_timer u_startup_timer (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .load       (load_pulse),
        .stop       (stop_pulse),
        .load_count (ctrl_merged[`COUNT_MSB:`COUNT_LSB]), // [RULE_04]
        .slow_rise  (slow_rise),
        .stable     (stable)
    );

    freq_meter u_freq_meter (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .stable     (stable),
        .slow_rise  (slow_rise),
        .slow_fall  (slow_fall),
        .main_rise  (main_rise),
        .freq_count (freq_count),
        .ready      (ready)
    );

    // Write channel
    always_comb
    begin
        aw_full_next = aw_full_reg;
        awaddr_next  = awaddr_reg;
        w_full_next  = w_full_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (s_axi_awvalid && awready_reg)
        begin
            aw_full_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_full_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
        awready_next = ~aw_full_next;
        wready_next  = ~w_full_next;
    end

    // Read channel
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (s_axi_arvalid && arready_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next  = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (s_axi_araddr)
                `CTRL_OFFSET:   rdata_next = ctrl_reg;
                `FREQ_OFFSET:   rdata_next = {15'h0000, ready, freq_count}; // [RULE_10]
                `STATUS_OFFSET: rdata_next = {31'h0000_0000, stable};
                `EVENT_OFFSET:  rdata_next = {30'h0000_0000, evt_reg};
                `MASK_OFFSET:   rdata_next = {30'h0000_0000, mask_reg};
                default:        rdata_next = 32'h0000_0000;
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
        arready_next = ~rvalid_next;
    end

    // Register file and interrupt
    always_comb
    begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        evt_next  = evt_reg;
        if (do_write && awaddr_reg == `CTRL_OFFSET)
        begin
            ctrl_next = 32'h0000_0000;
            ctrl_next[`ENABLE_BIT] = ctrl_merged[`ENABLE_BIT];
            ctrl_next[`BYPASS_BIT] = ctrl_merged[`BYPASS_BIT];
            ctrl_next[`COUNT_MSB:`COUNT_LSB] = ctrl_merged[`COUNT_MSB:`COUNT_LSB];
        end
        if (do_write && awaddr_reg == `MASK_OFFSET && wstrb_reg[0])
            mask_next = wdata_reg[`EVT_W-1:0];
        if (do_write && awaddr_reg == `EVENT_OFFSET && wstrb_reg[0])
            evt_next = evt_reg & ~wdata_reg[`EVT_W-1:0];
        evt_next     = evt_next | evt_set;
        irq_next     = |(evt_next & mask_next); // [RULE_06]
        on_main_next = stable & ctrl_next[`ENABLE_BIT]; // [RULE_01]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            aw_full_reg     <= 1'b0;
            awaddr_reg      <= 8'h00;
            w_full_reg      <= 1'b0;
            wdata_reg       <= 32'h0000_0000;
            wstrb_reg       <= 4'h0;
            awready_reg     <= 1'b0;
            wready_reg      <= 1'b0;
            bvalid_reg      <= 1'b0;
            bresp_reg       <= `RESP_OKAY;
            arready_reg     <= 1'b0;
            rvalid_reg      <= 1'b0;
            rresp_reg       <= `RESP_OKAY;
            rdata_reg       <= 32'h0000_0000;
            ctrl_reg        <= `CTRL_RESET; // [RULE_01]
            evt_reg         <= 2'h0;
            mask_reg        <= `MASK_RESET;
            irq_reg         <= 1'b0;
            on_main_reg     <= 1'b0;
            slow_reg        <= 1'b0;
            slow_prev_reg   <= 1'b0;
            main_reg        <= 1'b0;
            main_prev_reg   <= 1'b0;
            stable_prev_reg <= 1'b0;
            ready_prev_reg  <= 1'b0;
        end
        else
        begin
            aw_full_reg     <= aw_full_next;
            awaddr_reg      <= awaddr_next;
            w_full_reg      <= w_full_next;
            wdata_reg       <= wdata_next;
            wstrb_reg       <= wstrb_next;
            awready_reg     <= awready_next;
            wready_reg      <= wready_next;
            bvalid_reg      <= bvalid_next;
            bresp_reg       <= bresp_next;
            arready_reg     <= arready_next;
            rvalid_reg      <= rvalid_next;
            rresp_reg       <= rresp_next;
            rdata_reg       <= rdata_next;
            ctrl_reg        <= ctrl_next;
            evt_reg         <= evt_next;
            mask_reg        <= mask_next;
            irq_reg         <= irq_next;
            on_main_reg     <= on_main_next;
            slow_reg        <= slow_source_select ? slow_rc : slow_xtal; // [RULE_12] [RULE_13]
            slow_prev_reg   <= slow_reg;
            main_reg        <= main_clock;
            main_prev_reg   <= main_reg;
            stable_prev_reg <= stable;
            ready_prev_reg  <= ready;
        end
    end

    assign s_axi_awready   = awready_reg;
    assign s_axi_wready    = wready_reg;
    assign s_axi_bvalid    = bvalid_reg;
    assign s_axi_bresp     = bresp_reg;
    assign s_axi_arready   = arready_reg;
    assign s_axi_rvalid    = rvalid_reg;
    assign s_axi_rresp     = rresp_reg;
    assign s_axi_rdata     = rdata_reg;
    assign slow_clock      = slow_reg;
    assign main_osc_enable = ctrl_reg[`ENABLE_BIT];
    assign osc_bypass_a    = ctrl_reg[`BYPASS_BIT];
    assign main_osc_stable = stable;
    assign sys_on_main     = on_main_reg;
    assign irq             = irq_reg;

    a_reset_off: assert property (@(posedge sys_clk) // [RULE_01]
        !rstn |=> !main_osc_enable && !sys_on_main && !main_osc_stable)
        else $error("oscillator not off after reset");
    a_disable_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_02]
        stop_pulse |=> !main_osc_stable && !main_osc_enable)
        else $error("stable flag kept after oscillator disable");
    a_enable_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_03]
        load_pulse |=> !main_osc_stable && main_osc_enable)
        else $error("stable flag kept after enable write");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_06]
        irq == |(evt_reg & mask_reg))
        else $error("interrupt does not follow masked events");
    a_slow_source: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_12]
        ##1 slow_clock == ($past(slow_source_select) ? $past(slow_rc) : $past(slow_xtal)))
        else $error("slow clock does not follow selected source");
    sequence s_stable_rise;
        stable && !stable_prev_reg;
    endsequence
    a_stable_event: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_05]
        s_stable_rise |=> evt_reg[`EVT_STABLE_BIT])
        else $error("stable rise not recorded as event");
    a_ready_event: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_09]
        (ready && !ready_prev_reg) |=> evt_reg[`EVT_READY_BIT])
        else $error("measurement end not recorded as event");
    a_event_sticky: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_06]
        (evt_reg[`EVT_STABLE_BIT] && !(do_write && awaddr_reg == `EVENT_OFFSET))
        |=> evt_reg[`EVT_STABLE_BIT])
        else $error("stable event lost without clear");
    a_main_needs_enable: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_01]
        sys_on_main |-> main_osc_enable)
        else $error("system on main clock while oscillator disabled");
    a_slow_until_stable: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE_01]
        !main_osc_stable |=> !sys_on_main)
        else $error("system left slow clock before oscillator stable");
    a_write_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid)
        |=> ##1 s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read response missing");
endmodule : main_osc_control

// [tb/osc_source_model.sv]
`timescale 1ns/100ps
module osc_source_model #(
    parameter int XTAL_HALF = 4,
    parameter int RC_HALF   = 6,
    parameter int MAIN_HALF = 2,
    parameter int WARM_CYC  = 40
) (
    input  wire logic sys_clk,
    input  wire logic osc_on,
    input  wire logic ext_clk,
    output logic      slow_xtal,
    output logic      slow_rc,
    output logic      main_clock
);
    int xc = 0;
    int rc = 0;
    int mc = 0;
    int warm = 0;
    initial
    begin
        slow_xtal = 1'b0;
        slow_rc = 1'b0;
        main_clock = 1'b0;
    end
    // Both slow sources run free, whatever the select says
    always @(posedge sys_clk)
    begin
        xc = (xc + 1) % XTAL_HALF;
        rc = (rc + 1) % RC_HALF;
        if (xc == 0)
            slow_xtal <= !slow_xtal;
        if (rc == 0)
            slow_rc <= !slow_rc;
    end
    // Crystal needs a warm-up before it swings; an external clock runs at once
    always @(posedge sys_clk)
    begin
        warm = osc_on ? warm + 1 : 0;
        mc = (mc + 1) % MAIN_HALF;
        if (!(ext_clk || warm > WARM_CYC))
            main_clock <= 1'b0;
        else if (mc == 0)
            main_clock <= !main_clock;
    end
endmodule : osc_source_model

// [tb/tb_top.sv]
`timescale 1ns/100ps
`include "osc_regs.svh"
module tb_top
    import osc_pkg::*;
;
    logic        sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready, sel, prv, ps;
    logic        awready, wready, bvalid, arready, rvalid, slow_clock, en, byp;
    logic        stable, on_main, irq, xtal, rc, mclk;
    logic [7:0]  awaddr, araddr, cnt;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  bresp, rresp;
    logic [63:0] notes[$];
    int          bad_count, n_checks, cyc, n, tg;

    main_osc_control DUT (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .slow_xtal(xtal), .slow_rc(rc),
        .slow_source_select(sel), .main_clock(mclk), .slow_clock(slow_clock),
        .main_osc_enable(en), .osc_bypass_a(byp), .main_osc_stable(stable),
        .sys_on_main(on_main), .irq(irq));

    osc_source_model partner (.sys_clk(sys_clk), .osc_on(en), .ext_clk(byp),
        .slow_xtal(xtal), .slow_rc(rc), .main_clock(mclk));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic pop(input string what, input logic [31:0] seen);
        logic [63:0] e;
        e = notes.pop_front();
        chk(what, seen & e[63:32], e[31:0]);
    endtask : pop

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        notes.push_back({32'h0000_0003, 30'h0, er});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end while ((awvalid && !awready) || (wvalid && !wready) || !bvalid);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                      input logic [1:0] er);
        @(posedge sys_clk);
        notes.push_back({m, exp});
        notes.push_back({32'h0000_0003, 30'h0, er});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            arvalid <= arvalid && !arready;
        end while (!rvalid);
        got = rdata;
        rready <= 1'b0;
    endtask : rd

    task automatic wait_stable();
        n = 0;
        while (stable !== 1'b1 && n < 2000)
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_stable

    always @(posedge sys_clk)
    begin
        if (bvalid && bready)
            pop("bresp", {30'h0, bresp});
        if (rvalid && rready)
        begin
            pop("rdata", rdata);
            pop("rresp", {30'h0, rresp});
        end
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end

    initial
    begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, sel} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        void'($urandom(84));
        chk("enable", en, 1'b0);
        chk("on_main", on_main, 1'b0);
        rd(`CTRL_OFFSET, 32'h0, 32'hFFFF_FFFF, `RESP_OKAY);
        rd(`STATUS_OFFSET, 32'h0, 32'hFFFF_FFFF, `RESP_OKAY);
        rd(8'h14, 32'h0, 32'hFFFF_FFFF, `RESP_SLVERR);
        wr(8'h14, 32'hFFFF_FFFF, `RESP_SLVERR);
        $display("test reset done");
        cnt = 8'($urandom_range(3, 2));
        wr(`MASK_OFFSET, 32'h0000_0003, `RESP_OKAY);
        wr(`CTRL_OFFSET, {16'h0, cnt, 8'h01}, `RESP_OKAY);
        chk("stable_early", stable, 1'b0);
        wait_stable();
        chk("startup", 32'(n >= cnt * 64 - 16 && n <= cnt * 64 + 8), 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq_on", irq, 1'b1);
        chk("on_main", on_main, 1'b1);
        got = 32'h0;
        for (int i = 0; i < 60 && !got[16]; i++)
            rd(`FREQ_OFFSET, 32'h0, 32'h0, `RESP_OKAY);
        chk("freq", 32'(got[15:0] >= 30 && got[15:0] <= 33), 32'h1);
        rd(`EVENT_OFFSET, 32'h3, 32'h3, `RESP_OKAY);
        wr(`EVENT_OFFSET, 32'h0000_0003, `RESP_OKAY);
        rd(`EVENT_OFFSET, 32'h0, 32'h3, `RESP_OKAY);
        chk("irq_clr", irq, 1'b0);
        $display("test startup done");
        wr(`MASK_OFFSET, 32'h0, `RESP_OKAY);
        wr(`CTRL_OFFSET, 32'h0000_0101, `RESP_OKAY);
        chk("stable_reload", stable, 1'b0);
        wait_stable();
        rd(`FREQ_OFFSET, 32'h0, 32'h0001_0000, `RESP_OKAY);
        chk("irq_masked", irq, 1'b0);
        wr(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
        chk("stable_off", stable, 1'b0);
        chk("on_main_off", on_main, 1'b0);
        $display("test restart done");
        wr(`CTRL_OFFSET, 32'h0000_FF02, `RESP_OKAY);
        rd(`CTRL_OFFSET, 32'h0000_FF02, 32'hFFFF_FFFF, `RESP_OKAY);
        repeat (100) @(posedge sys_clk);
        chk("bypass", {byp, stable}, 2'h2);
        sel <= 1'b1;
        repeat (3) @(posedge sys_clk);
        prv = rc;
        ps = slow_clock;
        tg = 0;
        for (int i = 0; i < 30; i++)
        begin
            @(posedge sys_clk);
            chk("slow_rc", slow_clock, prv);
            tg += int'(slow_clock != ps);
            ps = slow_clock;
            prv = rc;
        end
        chk("slow_runs", 32'(tg >= 3), 32'h1);
        $display("test slow clock done");
        finish_test();
    end
endmodule : tb_top
